// ### rtl/mrl_defines.svh
// Purpose: offsets, field positions, reset values and counts of the role and link block
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef MRL_DEFINES_SVH
`define MRL_DEFINES_SVH

// register word offsets on the plain register port
`define MRL_CONFIG_OFFSET      4'h0
`define MRL_STATUS_OFFSET      4'h4
`define MRL_ADDR_W             4
// config register fields
`define MRL_CFG_RATE_LSB       0
`define MRL_CFG_RATE_W         2
`define MRL_CFG_SDR_BIT        2
`define MRL_CFG_RESET          32'h0000_0000
// status register fields
`define MRL_STS_ROLE_LSB       0
`define MRL_STS_ADDR_LSB       2
`define MRL_STS_LINK_BIT       9
`define MRL_STS_RATE_LSB       10
// 8b/10b running disparity after reset is negative
`define MRL_RD_RESET           1'b0
// topological address width
`define MRL_TOPO_W             7

`endif

// ### rtl/mrl_pkg.sv
// Purpose: types shared by the role and link block
// Assumes: nothing
// Notes:   binary codes written out for every enum
package mrl_pkg;

  // operating role decoded from the topological address
  typedef enum logic [1:0] {
    ROLE_INNER  = 2'b00,
    ROLE_MASTER = 2'b01,
    ROLE_SLAVE  = 2'b10
  } mrl_role_t;

  // line rate handed to the serialiser
  typedef enum logic [1:0] {
    RATE_1200 = 2'b00,
    RATE_600  = 2'b01,
    RATE_400  = 2'b10
  } mrl_rate_t;

  // one two-way pin seen from the core
  typedef struct packed {
    logic out;
    logic oe;
  } mrl_pin_t;

  // one encoded symbol toward the serialiser
  typedef struct packed {
    logic       valid;
    logic [9:0] symbol;
  } mrl_sym_t;

endpackage

// ### rtl/mrl_core.sv
// Purpose: port roles, clock steering, reset merge and data link path of a pixel chip
// Assumes: all inputs synchronous to ref_clk; the analog serialiser takes 10-bit symbols
// Notes:   control protocol and matrix readout sit outside; they drive the txReq ports
//
// Functional notes
// - inner chip drives its own serial output from the link transmit unit
// - inner chip line rate is 1200, 600 or 400; 1200 after reset
// - every outgoing byte is 8b/10b encoded before serialising
// - master and slaves take turns on the local data bus by token
// - master samples local bus every cycle and copies bytes to serial output
// - master retransmits at fixed 400 and encodes 8b/10b itself
// - slave keeps link transmit unit off and serial output unused
// - core clock always comes from main clock port receiver
// - master enables main clock port driver, forwarding the forwarded clock input
// - forwarded clock input driver is always disabled
// - forwarded clock receiver enabled only in master role
// - low power-on-reset mask ignores the internal power-on reset
// - a control reset command resets the chip like the pin
// - seven-bit topological address selects control transactions for this chip
// - role is derived from the topological address
// - open address pins read zero, supply-tied pins read one
// - slave neither drives nor uses the differential control port
// - inner chip neither drives nor uses the single-ended control port
// - control ports are half-duplex, never driven while receiving
// - master operates both control ports, relaying between them
// - serial control stream sampled only on rising system clock edges
`include "mrl_defines.svh"

module mrl_core #(
  parameter int TOPO_W = `MRL_TOPO_W,
  // two bits per address value, indexed by address; see default below
  parameter logic [2*(2**`MRL_TOPO_W)-1:0] ROLE_TABLE = mrl_default_table()
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  // reset sources
  input  wire logic              powerOnReset,
  input  wire logic              power_on_reset_mask_n,
  input  wire logic              resetCmd,
  output logic                   coreRstN,
  // topological address pins and match
  input  wire logic [TOPO_W-1:0] topo_address,
  input  wire logic [TOPO_W-1:0] ctrlTargetAddr,
  output logic                   addrMatch,
  output mrl_pkg::mrl_role_t     role,
  // clock ports
  input  wire logic              mainClkRx,
  input  wire logic              fwdClkRx,
  output logic                   coreClk,
  output mrl_pkg::mrl_pin_t      main_clock_port,
  output logic                   fwdClkRxEn,
  output logic                   fwdClkDrvEn,
  // control ports and the control unit's side
  input  wire logic              diffCtrlIn,
  output mrl_pkg::mrl_pin_t      diff_control_port,
  input  wire logic              seCtrlIn,
  output mrl_pkg::mrl_pin_t      seCtrl,
  input  wire logic              ctrlTxReq,
  input  wire logic              ctrlTxBit,
  input  wire logic              relayUp,
  output logic                   ctrlRxBit,
  output logic                   ctrlRxValid,
  // own readout bytes
  input  wire logic [7:0]        ownByte,
  input  wire logic              ownValid,
  output logic                   ownReady,
  // local shared data bus
  input  wire logic              tokenHeld,
  input  wire logic [7:0]        localDataIn,
  output logic [7:0]             localDataOut,
  output logic                   localDataOe,
  // link transmit unit
  input  wire logic              serReady,
  output logic                   link_transmit_unit_en,
  output mrl_pkg::mrl_rate_t     lineRate,
  output mrl_pkg::mrl_sym_t      serial_data_out,
  // register port
  input  wire logic [`MRL_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata
);

  // default mapping: module field zero is inner; otherwise nibble zero is
  // master and any other nibble is slave
  function automatic logic [2*(2**`MRL_TOPO_W)-1:0] mrl_default_table();
    logic [2*(2**`MRL_TOPO_W)-1:0] t;
    t = '0;
    for (int a = 0; a < 2**`MRL_TOPO_W; a++) begin
      if ((a >> 4) == 0) begin
        t[2*a +: 2] = mrl_pkg::ROLE_INNER;
      end else if ((a & 15) == 0) begin
        t[2*a +: 2] = mrl_pkg::ROLE_MASTER;
      end else begin
        t[2*a +: 2] = mrl_pkg::ROLE_SLAVE;
      end
    end
    return t;
  endfunction

  // 8b/10b encoder: returns {new disparity, abcdei, fghj}
  function automatic logic [10:0] mrl_enc(input logic [7:0] d, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic       rd1;
    logic       alt;
    s6 = 6'h00;
    s4 = 4'h0;
    unique case (d[4:0])
      5'h00: s6 = 6'h27;  5'h01: s6 = 6'h1d;  5'h02: s6 = 6'h2d;  5'h03: s6 = 6'h31;
      5'h04: s6 = 6'h35;  5'h05: s6 = 6'h29;  5'h06: s6 = 6'h19;  5'h07: s6 = 6'h38;
      5'h08: s6 = 6'h39;  5'h09: s6 = 6'h25;  5'h0a: s6 = 6'h15;  5'h0b: s6 = 6'h34;
      5'h0c: s6 = 6'h0d;  5'h0d: s6 = 6'h2c;  5'h0e: s6 = 6'h1c;  5'h0f: s6 = 6'h17;
      5'h10: s6 = 6'h1b;  5'h11: s6 = 6'h23;  5'h12: s6 = 6'h13;  5'h13: s6 = 6'h32;
      5'h14: s6 = 6'h0b;  5'h15: s6 = 6'h2a;  5'h16: s6 = 6'h1a;  5'h17: s6 = 6'h3a;
      5'h18: s6 = 6'h33;  5'h19: s6 = 6'h26;  5'h1a: s6 = 6'h16;  5'h1b: s6 = 6'h36;
      5'h1c: s6 = 6'h0e;  5'h1d: s6 = 6'h2e;  5'h1e: s6 = 6'h1e;  5'h1f: s6 = 6'h2b;
    endcase
    // unbalanced codes and the D.7 pair flip in positive disparity
    if (rd && (($countones(s6) != 3) || (d[4:0] == 5'h07))) begin
      s6 = ~s6;
    end
    rd1 = rd ^ ($countones(s6) != 3);
    // alternate D.x.7 avoids a run of five equal bits
    alt = (!rd1 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
          (rd1 && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e));
    unique case (d[7:5])
      3'h0: s4 = 4'hb;
      3'h1: s4 = 4'h9;
      3'h2: s4 = 4'h5;
      3'h3: s4 = 4'hc;
      3'h4: s4 = 4'hd;
      3'h5: s4 = 4'ha;
      3'h6: s4 = 4'h6;
      3'h7: s4 = alt ? 4'h7 : 4'he;
    endcase
    if (rd1 && (d[7:5] == 3'h0 || d[7:5] == 3'h3 || d[7:5] == 3'h4 || d[7:5] == 3'h7)) begin
      s4 = ~s4;
    end
    return {rd1 ^ ($countones(s4) != 2), s6, s4};
  endfunction

  // build-time check: the address must fit the table
  if (TOPO_W != `MRL_TOPO_W) begin : gBadWidth
    $error("mrl_core: topological address width must be seven");
  end

  logic [TOPO_W-1:0]    topo_reg;
  mrl_pkg::mrl_role_t   role_reg;
  logic                 rst_reg;
  logic [31:0]          config_reg;
  logic [31:0]          rdata_reg;
  logic                 rd_reg;
  logic                 rxBit_reg;
  logic                 rxValid_reg;
  mrl_pkg::mrl_sym_t    sym_reg;
  logic [7:0]           busOut_reg;
  logic                 busOe_reg;
  logic                 isInner;
  logic                 isMaster;
  logic                 isSlave;
  logic                 porActive;
  logic                 rstNext;
  logic [1:0]           roleNext;
  logic [7:0]           txByte;
  logic                 txValid;
  logic                 txTake;
  logic [10:0]          encOut;
  logic                 diffDrive;
  logic                 seDrive;
  logic                 diffRelay;
  logic                 seRelay;

  // masked power-on reset merged with the pin and the control command
  assign porActive = powerOnReset & power_on_reset_mask_n;
  assign rstNext   = !rst_n || porActive || resetCmd;

  // reset is registered so every later process sees a clean level
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      rst_reg <= rstNext;
    end
  end
  assign coreRstN = !rst_reg;

  // address pins read directly; pull-downs make open pins zero
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg) begin
        topo_reg <= '0;
      end else begin
        topo_reg <= topo_address;
      end
    end
  end

  // role lookup from the build-time table
  assign roleNext = ROLE_TABLE[2*topo_address +: 2];
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg) begin
        role_reg <= mrl_pkg::ROLE_INNER;
      end else if (roleNext == mrl_pkg::ROLE_MASTER || roleNext == mrl_pkg::ROLE_SLAVE) begin
        role_reg <= mrl_pkg::mrl_role_t'(roleNext);
      end else begin
        role_reg <= mrl_pkg::ROLE_INNER;                                // illegal code: inner
      end
    end
  end
  assign role     = role_reg;
  assign isInner  = role_reg == mrl_pkg::ROLE_INNER;
  assign isMaster = role_reg == mrl_pkg::ROLE_MASTER;
  assign isSlave  = role_reg == mrl_pkg::ROLE_SLAVE;

  // control transactions are ours when the target matches the registered address
  assign addrMatch = ctrlTargetAddr == topo_reg;

  // clock steering; these are analog enables, the clocks themselves pass straight through
  assign coreClk                = mainClkRx;
  assign fwdClkRxEn             = isMaster;
  assign fwdClkDrvEn            = 1'b0;
  assign main_clock_port.oe     = isMaster;
  assign main_clock_port.out    = isMaster & fwdClkRx;

  // control port drive: own answers go up the differential port, a slave's up the single-ended one; a master also
  // relays, downward while the far side talks, upward while a slave answers
  assign diffRelay = isMaster && relayUp && !ctrlTxReq;
  assign seRelay   = isMaster && !relayUp;
  assign diffDrive = !isSlave && (ctrlTxReq || diffRelay);
  assign seDrive   = !isInner && ((isSlave && ctrlTxReq) || seRelay);

  // a port that drives never samples, so one direction is live at a time
  assign diff_control_port.oe  = diffDrive;
  assign diff_control_port.out = diffDrive & (ctrlTxReq ? ctrlTxBit : seCtrlIn);
  assign seCtrl.oe             = seDrive;
  assign seCtrl.out            = seDrive & (isSlave ? ctrlTxBit : diffCtrlIn);

  // control stream sampled on the rising edge from whichever port is listening
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg) begin
        rxBit_reg   <= 1'b1;
        rxValid_reg <= 1'b0;
      end else if (isSlave) begin
        rxBit_reg   <= seCtrlIn;
        rxValid_reg <= !seDrive;
      end else begin
        rxBit_reg   <= diffCtrlIn;
        rxValid_reg <= !diffDrive;
      end
    end
  end
  assign ctrlRxBit   = rxBit_reg;
  assign ctrlRxValid = rxValid_reg;

  // local bus: a module chip drives its byte only in the cycle after it holds the token
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg) begin
        busOut_reg <= 8'h00;
        busOe_reg  <= 1'b0;
      end else begin
        busOe_reg  <= !isInner && tokenHeld && ownValid;
        busOut_reg <= ownValid ? ownByte : 8'hff;
      end
    end
  end
  assign localDataOut = busOut_reg;
  assign localDataOe  = busOe_reg;

  // byte source for the link: own bytes in inner role, the bus copy in master role;
  // a master cannot stall the bus, so its bytes are sent every cycle regardless
  assign txByte   = isMaster ? localDataIn : ownByte;
  assign txValid  = isMaster ? 1'b1 : (isInner && ownValid);
  assign txTake   = txValid && (isMaster || serReady);
  assign ownReady = isInner ? serReady : (!isInner && tokenHeld);
  assign encOut   = mrl_enc(txByte, rd_reg);

  // encoder output register and running disparity
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg || isSlave) begin
        sym_reg <= '0;
        rd_reg  <= `MRL_RD_RESET;
      end else if (txTake) begin
        sym_reg <= '{valid: 1'b1, symbol: encOut[9:0]};
        rd_reg  <= encOut[10];
      end else if (serReady) begin
        sym_reg.valid <= 1'b0;
      end
    end
  end
  assign serial_data_out = sym_reg;

  // transmit unit on only in roles that own a link
  assign link_transmit_unit_en = !isSlave;

  // rate: programmable for inner chips, fixed for masters
  always_comb begin
    if (isMaster) begin
      lineRate = mrl_pkg::RATE_400;
    end else if (config_reg[`MRL_CFG_RATE_LSB +: `MRL_CFG_RATE_W] == mrl_pkg::RATE_600) begin
      lineRate = mrl_pkg::RATE_600;
    end else if (config_reg[`MRL_CFG_RATE_LSB +: `MRL_CFG_RATE_W] == mrl_pkg::RATE_400) begin
      lineRate = mrl_pkg::RATE_400;
    end else begin
      lineRate = mrl_pkg::RATE_1200;
    end
  end

  // config write; reset value selects the top rate
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg) begin
        config_reg <= `MRL_CFG_RESET;
      end else if (regWr && regAddr == `MRL_CONFIG_OFFSET) begin
        config_reg <= {29'h0, regWdata[2:0]};
      end
    end
  end

  // read data stands in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (rst_reg || !regRd) begin
        rdata_reg <= 32'h0000_0000;
      end else if (regAddr == `MRL_CONFIG_OFFSET) begin
        rdata_reg <= config_reg;
      end else if (regAddr == `MRL_STATUS_OFFSET) begin
        rdata_reg <= {20'h0_0000, lineRate, link_transmit_unit_en, topo_reg, role_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign regRdata = rdata_reg;

endmodule

// ### testbench/mrl_core_checker.sv
// Purpose: concurrent checks on the role, clock steering and link ports
// Assumes: one clock domain, synchronous active-low reset pin
// Notes:   bound to mrl_core from the bench top file
module mrl_core_checker (
  input logic               ref_clk,
  input logic               rst_n,
  input logic               coreRstN,
  input logic               powerOnReset,
  input logic               power_on_reset_mask_n,
  input logic               resetCmd,
  input mrl_pkg::mrl_role_t role,
  input logic               fwdClkRx,
  input mrl_pkg::mrl_pin_t  main_clock_port,
  input logic               fwdClkRxEn,
  input logic               fwdClkDrvEn,
  input logic               diffCtrlIn,
  input mrl_pkg::mrl_pin_t  diff_control_port,
  input mrl_pkg::mrl_pin_t  seCtrl,
  input logic               ctrlRxBit,
  input logic               ctrlRxValid,
  input logic               link_transmit_unit_en,
  input mrl_pkg::mrl_rate_t lineRate,
  input mrl_pkg::mrl_sym_t  serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // shorthand for the decoded role
  logic isM;
  logic isS;
  logic isI;
  assign isM = role == mrl_pkg::ROLE_MASTER;
  assign isS = role == mrl_pkg::ROLE_SLAVE;
  assign isI = role == mrl_pkg::ROLE_INNER;

  // clock steering is a pure function of the role
  property p_drv_off; fwdClkDrvEn == 1'b0; endproperty
  a_drv_off: assert property (p_drv_off) else $error("forward driver enabled");
  property p_rx_en; fwdClkRxEn == isM; endproperty
  a_rx_en: assert property (p_rx_en) else $error("forward receiver enable wrong");
  property p_clk_fwd; main_clock_port == {isM & fwdClkRx, isM}; endproperty
  a_clk_fwd: assert property (p_clk_fwd) else $error("main clock port wrong");

  // link path per role; two cycles let a role change settle
  property p_slave_off; isS [*2] |-> !link_transmit_unit_en && !serial_data_out.valid; endproperty
  a_slave_off: assert property (p_slave_off) else $error("slave link active");
  property p_master_rate; isM |-> lineRate == mrl_pkg::RATE_400; endproperty
  a_master_rate: assert property (p_master_rate) else $error("master rate wrong");
  property p_master_copy; isM ##1 isM |-> serial_data_out.valid; endproperty
  a_master_copy: assert property (p_master_copy) else $error("master skipped a byte");

  // control port ownership and half-duplex sampling
  property p_diff_slave; isS |-> !diff_control_port.oe; endproperty
  a_diff_slave: assert property (p_diff_slave) else $error("slave drives diff port");
  property p_se_inner; isI |-> !seCtrl.oe; endproperty
  a_se_inner: assert property (p_se_inner) else $error("inner drives local port");
  property p_half; isI && diff_control_port.oe |=> !isI || !ctrlRxValid; endproperty
  a_half: assert property (p_half) else $error("received while driving");
  property p_sample;
    isI && coreRstN && !diff_control_port.oe |=>
      !isI || (ctrlRxValid && ctrlRxBit == $past(diffCtrlIn));
  endproperty
  a_sample: assert property (p_sample) else $error("control bit not sampled");

  // reset merge: command acts; masked power-on reset, like no cause at all, does not
  property p_cmd; resetCmd |=> !coreRstN; endproperty
  a_cmd: assert property (p_cmd) else $error("command reset ignored");
  property p_por_mask;
    (rst_n && !resetCmd && !(powerOnReset && power_on_reset_mask_n)) [*2] |-> coreRstN;
  endproperty
  a_por_mask: assert property (p_por_mask) else $error("reset without cause");
endmodule

// ### testbench/mrl_bus_peer.sv
// Purpose: far side of the block: a peer chip on the local bus and the serialiser
// Assumes: the bench hands the peer its turns on the local bus
// Notes:   a released bus floats to all ones through the pull-ups
module mrl_bus_peer (
  input  logic       ref_clk,
  input  logic       rst_n,
  input  logic       peerDrive,
  input  logic [7:0] peerByte,
  input  logic [7:0] dutByte,
  input  logic       dutOe,
  input  logic       stall,
  output logic [7:0] busLevel,
  output logic       serReady
);
  timeunit 1ns;
  timeprecision 100ps;

  // wired bus; two drivers at once give an unknown byte, so a clash cannot hide
  always_comb begin
    case ({dutOe, peerDrive})
      2'b10:   busLevel = dutByte;
      2'b01:   busLevel = peerByte;
      2'b00:   busLevel = 8'hff;
      default: busLevel = 8'hxx;
    endcase
  end

  // a stalling serialiser takes a symbol every other cycle only
  always_ff @(posedge ref_clk) begin
    serReady <= !rst_n ? 1'b1 : (stall ? ~serReady : 1'b1);
  end
endmodule

// ### testbench/mrl_core_tb.sv
// Purpose: self-checking bench for the role and link block
// Assumes: default address-to-role table; clock enable high except while the slave test freezes the role
// Notes:   exact symbols are checked only from negative running disparity
`include "mrl_defines.svh"
module mrl_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, powerOnReset = 1'b0;
  logic power_on_reset_mask_n = 1'b1, resetCmd = 1'b0, mainClkRx = 1'b0, fwdClkRx = 1'b0;
  logic diffCtrlIn = 1'b0, seCtrlIn = 1'b0, ctrlTxReq = 1'b0, ctrlTxBit = 1'b0;
  logic relayUp = 1'b0, ownValid = 1'b0, tokenHeld = 1'b0, peerDrive = 1'b0, stall = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, serReady, rdPos, pend;
  logic [6:0] topoDrv = 7'h00, ctrlTargetAddr = 7'h00;
  tri0  [6:0] topoPins;
  logic [7:0] ownByte = 8'h00, peerByte = 8'h00, busLevel, localDataOut, prevB, lastOwn;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic coreRstN, addrMatch, coreClk, fwdClkRxEn, fwdClkDrvEn, ctrlRxBit, ctrlRxValid;
  logic ownReady, localDataOe, link_transmit_unit_en;
  mrl_pkg::mrl_role_t role;
  mrl_pkg::mrl_rate_t lineRate;
  mrl_pkg::mrl_pin_t  main_clock_port, diff_control_port, seCtrl;
  mrl_pkg::mrl_sym_t  serial_data_out;
  int errors = 0, cmp_count = 0, cyc = 0;

  assign topoPins = topoDrv; // undriven bits fall to zero like open pins
  always #4 ref_clk = ~ref_clk;

  mrl_core uut (
    .ref_clk, .rst_n, .clkEn, .powerOnReset, .power_on_reset_mask_n, .resetCmd, .coreRstN,
    .topo_address(topoPins), .ctrlTargetAddr, .addrMatch, .role, .mainClkRx, .fwdClkRx,
    .coreClk, .main_clock_port, .fwdClkRxEn, .fwdClkDrvEn, .diffCtrlIn, .diff_control_port,
    .seCtrlIn, .seCtrl, .ctrlTxReq, .ctrlTxBit, .relayUp, .ctrlRxBit, .ctrlRxValid, .ownByte,
    .ownValid, .ownReady, .tokenHeld, .localDataIn(busLevel), .localDataOut, .localDataOe,
    .serReady, .link_transmit_unit_en, .lineRate, .serial_data_out, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata);
  mrl_bus_peer peer (.ref_clk, .rst_n, .peerDrive, .peerByte, .dutByte(localDataOut),
    .dutOe(localDataOe), .stall, .busLevel, .serReady);

  // control and clock pins wander at random; the run is cut short if it hangs
  always @(posedge ref_clk) begin
    {mainClkRx, fwdClkRx, diffCtrlIn, seCtrlIn, ctrlTxReq, ctrlTxBit, relayUp} <= 7'($urandom);
    ctrlTargetAddr <= ($urandom % 4 == 0) ? topoPins : 7'($urandom);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pin_reset(input logic [6:0] t);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    ownValid <= 1'b0; // a leftover byte would be taken in the inner cycle after reset
    topoDrv <= t;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rdPos = 1'b0;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask

  // three bytes whose codes are neutral from negative disparity
  function automatic logic [9:0] known_sym(input logic [7:0] b);
    return b == 8'h00 ? 10'h274 : (b == 8'hb5 ? 10'h2aa : 10'h2b1);
  endfunction

  // a 10-bit code may only lean against the running disparity
  task automatic sym_chk(input logic [7:0] b);
    int n;
    n = $countones(serial_data_out.symbol);
    chk("symbol valid", 32'h1, 32'(serial_data_out.valid));
    if (!rdPos && b inside {8'h00, 8'hb5, 8'hff})
      chk("symbol", 32'(known_sym(b)), 32'(serial_data_out.symbol));
    chk("disparity", 32'h1, 32'(rdPos ? n inside {4, 5} : n inside {5, 6}));
    if (n != 5)
      rdPos = ~rdPos;
  endtask

  task automatic test_inner;
    logic [31:0] d;
    pin_reset(7'bzzz_z101);
    chk("reset rate", 32'(mrl_pkg::RATE_1200), 32'(lineRate));
    reg_rd(`MRL_STATUS_OFFSET, d);
    chk("status", {20'h0, 2'b00, 1'b1, 7'h05, 2'b00}, d);
    for (int r = 1; r < 4; r++) begin
      reg_wr(`MRL_CONFIG_OFFSET, 32'(r) | 32'h4);
      chk("rate", r == 3 ? 32'h0 : 32'(r), 32'(lineRate));
    end
    reg_wr(4'hc, 32'hffff_ffff);
    reg_rd(`MRL_CONFIG_OFFSET, d);
    chk("config", 32'h7, d);
    reg_rd(4'h8, d);
    chk("unmapped", 32'h0, d);
    pend = 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      ownValid <= (i < 3) || ($urandom % 2 == 1);
      ownByte <= i == 0 ? 8'h00 : (i == 1 ? 8'hb5 : (i == 2 ? 8'hff : 8'($urandom)));
      stall <= i > 10; // back-to-back first, then a stalling serialiser
      @(negedge ref_clk);
      if (pend)
        sym_chk(prevB);
      chk("own ready", 32'(serReady), 32'(ownReady));
      chk("core clock", 32'(mainClkRx), 32'(coreClk));
      chk("match", 32'(ctrlTargetAddr == 7'h05), 32'(addrMatch));
      pend = ownValid && serReady;
      prevB = ownByte;
    end
    $display("test inner done");
  endtask

  task automatic test_master;
    logic upBit;
    pin_reset(7'h10);
    @(posedge ref_clk);
    resetCmd <= 1'b1;
    @(posedge ref_clk);
    resetCmd <= 1'b0;
    @(negedge ref_clk);
    chk("command reset", 32'h0, 32'(coreRstN));
    reg_wr(`MRL_CONFIG_OFFSET, 32'h1);
    chk("role", 32'(mrl_pkg::ROLE_MASTER), 32'(role));
    chk("master rate", 32'(mrl_pkg::RATE_400), 32'(lineRate));
    prevB = busLevel;
    // own turns and peer turns alternate with idle gaps between them
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk);
      tokenHeld <= i % 20 < 8;
      ownValid <= i % 20 < 8;
      ownByte <= 8'($urandom);
      peerDrive <= (i % 20 inside {[10:17]}) && ($urandom % 4 != 0);
      peerByte <= 8'($urandom);
      @(negedge ref_clk);
      sym_chk(prevB);
      upBit = ctrlTxReq ? ctrlTxBit : relayUp & seCtrlIn;
      chk("relay up", 32'({upBit, ctrlTxReq | relayUp}), 32'(diff_control_port));
      chk("relay down", 32'({!relayUp & diffCtrlIn, !relayUp}), 32'(seCtrl));
      if (i % 20 inside {[1:8]})
        chk("bus drive", {23'h0, 1'b1, lastOwn}, {23'h0, localDataOe, localDataOut});
      prevB = busLevel;
      lastOwn = ownByte;
    end
    $display("test master done");
  endtask

  task automatic test_slave;
    logic [31:0] d;
    pin_reset(7'h13);
    reg_rd(`MRL_STATUS_OFFSET, d);
    chk("status", {20'h0, 2'b00, 1'b0, 7'h13, 2'b10}, d & 32'h0000_03ff);
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      ownValid <= 1'b1;
      ownByte <= 8'($urandom);
      @(negedge ref_clk);
      chk("slave symbol", 32'h0, 32'(serial_data_out.valid));
      chk("slave unit", 32'h0, 32'(link_transmit_unit_en));
    end
    // pins move while the clock enable is low; the role must hold until it returns
    @(posedge ref_clk);
    clkEn <= 1'b0;
    topoDrv <= 7'h05;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("frozen role", 32'(mrl_pkg::ROLE_SLAVE), 32'(role));
    @(posedge ref_clk);
    clkEn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("thawed role", 32'(mrl_pkg::ROLE_INNER), 32'(role));
    $display("test slave done");
  endtask

  task automatic test_por;
    @(posedge ref_clk);
    power_on_reset_mask_n <= 1'b0;
    powerOnReset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("masked por", 32'h1, 32'(coreRstN));
    @(posedge ref_clk);
    power_on_reset_mask_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("unmasked por", 32'h0, 32'(coreRstN));
    @(posedge ref_clk);
    powerOnReset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    $display("test por done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    void'($urandom(96260));
    test_inner();
    test_master();
    test_slave();
    test_por();
    wrap_up();
  end
endmodule

bind mrl_core mrl_core_checker u_chk (
  .ref_clk, .rst_n, .coreRstN, .powerOnReset, .power_on_reset_mask_n, .resetCmd, .role,
  .fwdClkRx, .main_clock_port, .fwdClkRxEn, .fwdClkDrvEn, .diffCtrlIn, .diff_control_port,
  .seCtrl, .ctrlRxBit, .ctrlRxValid, .link_transmit_unit_en, .lineRate, .serial_data_out);
